// ---- rtl/rtcsq_cfg.svh ----
// register offsets, field positions, masks and reset values of the clock core
// assumes inclusion by the core module, the checker and the bench only
// Functional notes
// - disabled wave pin follows idle-level bit
// - enable bit starts square wave output
// - at 1 Hz, counters update on falling edge
// - rate field picks 1/4096/8192/32768 Hz
// - seconds 00..59, wrap bumps minutes
// - minutes 00..59, wrap bumps hours
// - hour day-change carries date and weekday
// - hour-format bit: 0 is 24h, 1 12h
// - 12h hours: format, pm flag, 01..12
// - weekday counts 01..07 then 01
// - date wraps by month length, leap aware
// - month 1..12, wrap bumps year
// - year 00..99, multiples of four leap
// - all counters kept in packed BCD
// - fixed-zero bits always read zero
// - oscillator stop keeps counter chain intact
`ifndef RTCSQ_CFG_SVH
`define RTCSQ_CFG_SVH

// register offsets
`define RTCSQ_OFS_SECONDS   3'h0
`define RTCSQ_OFS_MINUTES   3'h1
`define RTCSQ_OFS_HOURS     3'h2
`define RTCSQ_OFS_WEEKDAY   3'h3
`define RTCSQ_OFS_DATE      3'h4
`define RTCSQ_OFS_MONTH     3'h5
`define RTCSQ_OFS_YEAR      3'h6
`define RTCSQ_OFS_CONTROL   3'h7

// writable bit masks; zero bits are fixed zero
`define RTCSQ_MASK_SECONDS  8'hFF
`define RTCSQ_MASK_MINUTES  8'h7F
`define RTCSQ_MASK_HOURS    8'h7F
`define RTCSQ_MASK_WEEKDAY  8'h07
`define RTCSQ_MASK_DATE     8'h3F
`define RTCSQ_MASK_MONTH    8'h1F
`define RTCSQ_MASK_YEAR     8'hFF
`define RTCSQ_MASK_CONTROL  8'h93

// field positions
`define RTCSQ_BIT_OSC_DIS   7
`define RTCSQ_BIT_FMT12     6
`define RTCSQ_BIT_PM        5
`define RTCSQ_BIT_IDLE_LVL  7
`define RTCSQ_BIT_WAVE_EN   4

// reset values (counter contents are undefined, zero chosen, 01 for weekday, date and month)
`define RTCSQ_RST_CONTROL   8'h03
`define RTCSQ_RST_COUNT     8'h00
`define RTCSQ_RST_WEEKDAY   8'h01
`define RTCSQ_RST_DATE      8'h01
`define RTCSQ_RST_MONTH     8'h01

// oscillator prescaler: 32768 edges make one second
`define RTCSQ_PRESCALE_W    15
`define RTCSQ_PRESCALE_MAX  15'h7FFF

`endif

// ---- rtl/rtcsq_core.sv ----
// timekeeping core: bcd calendar counters, prescaler and square-wave output
// assumes a byte register port fed by the serial interface on clk and a raw
// 32.768 kHz oscillator level on osc_pin from outside the clk domain
`timescale 1ns/1ps
`include "rtcsq_cfg.svh"

module rtcsq_core (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       osc_pin,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata,
  output logic            wave_output_pin,
  output logic            second_tick
);

  // bcd increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r[3:0] = 4'h0;
      r[7:4] = v[7:4] + 4'h1;
    end else begin
      r[3:0] = v[3:0] + 4'h1;
    end
    return r;
  endfunction : bcd_inc

  // registers
  logic [7:0] seconds_count;
  logic [7:0] minutes_count;
  logic [7:0] hours_count;
  logic [7:0] weekday_count;
  logic [7:0] date_count;
  logic [7:0] month_count;
  logic [7:0] year_count;
  logic [7:0] wave_output_control;

  logic [7:0] next_seconds;
  logic [7:0] next_minutes;
  logic [7:0] next_hours;
  logic [7:0] next_weekday;
  logic [7:0] next_date;
  logic [7:0] next_month;
  logic [7:0] next_year;
  logic [7:0] next_rdata;

  // oscillator pin synchroniser, third stage only for edge detection
  logic osc_meta;
  logic osc_sync;
  logic osc_prev;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= osc_pin;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  // oscillator gating: disabled oscillator just stops edges, chain holds state
  wire osc_disabled = seconds_count[`RTCSQ_BIT_OSC_DIS];
  wire osc_rise     = osc_sync & ~osc_prev & ~osc_disabled;

  // prescaler divides oscillator edges by 32768
  logic [`RTCSQ_PRESCALE_W-1:0] prescale;
  wire prescale_wrap = osc_rise && (prescale == `RTCSQ_PRESCALE_MAX);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prescale <= '0;
    end else if (osc_rise) begin
      prescale <= prescale + 15'h0001;
    end
  end

  // msb of prescaler falls exactly when it wraps, so the tick sits on the
  // falling edge of the 1 Hz wave
  wire tick = prescale_wrap;

  // control fields
  wire                 wave_en   = wave_output_control[`RTCSQ_BIT_WAVE_EN];
  wire                 idle_lvl  = wave_output_control[`RTCSQ_BIT_IDLE_LVL];
  rtcsq_pkg::rtcsq_rate_e rate;
  assign rate = rtcsq_pkg::rtcsq_rate_e'(wave_output_control[1:0]);

  // selected square-wave source
  // the 32.768k choice follows the synced level, so it keeps running while halted
  logic wave_src;
  always_comb begin
    case (rate)
      rtcsq_pkg::RTCSQ_RATE_1HZ:    wave_src = prescale[14];
      rtcsq_pkg::RTCSQ_RATE_4096HZ: wave_src = prescale[2];
      rtcsq_pkg::RTCSQ_RATE_8192HZ: wave_src = prescale[1];
      rtcsq_pkg::RTCSQ_RATE_32KHZ:  wave_src = osc_sync;
      default:                      wave_src = 1'b0;
    endcase
  end

  // pin driver: static level when wave disabled
  wire next_wave = wave_en ? wave_src : idle_lvl;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wave_output_pin <= 1'b0;
      second_tick     <= 1'b0;
    end else begin
      wave_output_pin <= next_wave;
      second_tick     <= tick;
    end
  end

  // carry chain decode; all values packed bcd
  wire sec_wrap = tick && (seconds_count[6:0] == 7'h59);
  wire min_wrap = sec_wrap && (minutes_count[6:0] == 7'h59);
  wire fmt12    = hours_count[`RTCSQ_BIT_FMT12];
  wire pm       = hours_count[`RTCSQ_BIT_PM];
  wire [4:0] hr12 = hours_count[4:0];
  wire [5:0] hr24 = hours_count[5:0];
  wire day_wrap = min_wrap && (fmt12 ? (pm && hr12 == 5'h11)
                                     : (hr24 == 6'h23));

  // incremented digits as named wires; a call result cannot be part-selected
  wire [7:0] sec_inc  = bcd_inc({1'b0, seconds_count[6:0]});
  wire [7:0] hr12_inc = bcd_inc({3'b000, hr12});
  wire [7:0] hr24_inc = bcd_inc({2'b00, hr24});

  // leap year: bcd value divisible by four
  // two digits only, so no century exception is needed
  wire tens_odd = year_count[4];
  wire [3:0] yu = year_count[3:0];
  wire leap = tens_odd ? (yu == 4'h2 || yu == 4'h6)
                       : (yu == 4'h0 || yu == 4'h4 || yu == 4'h8);

  // month length
  wire [4:0] mon = month_count[4:0];
  wire short_mon = (mon == 5'h04) || (mon == 5'h06) || (mon == 5'h09) || (mon == 5'h11);
  wire [5:0] last_date = (mon == 5'h02) ? (leap ? 6'h29 : 6'h28)
                                        : (short_mon ? 6'h30 : 6'h31);
  wire date_wrap = day_wrap && (date_count[5:0] == last_date);
  wire mon_wrap  = date_wrap && (mon == 5'h12);

  // register write decode
  // a write on a carry edge wins for its own register, the carry still ripples on
  wire wr_sec  = reg_we && (reg_addr == `RTCSQ_OFS_SECONDS);
  wire wr_min  = reg_we && (reg_addr == `RTCSQ_OFS_MINUTES);
  wire wr_hour = reg_we && (reg_addr == `RTCSQ_OFS_HOURS);
  wire wr_wday = reg_we && (reg_addr == `RTCSQ_OFS_WEEKDAY);
  wire wr_date = reg_we && (reg_addr == `RTCSQ_OFS_DATE);
  wire wr_mon  = reg_we && (reg_addr == `RTCSQ_OFS_MONTH);
  wire wr_year = reg_we && (reg_addr == `RTCSQ_OFS_YEAR);
  wire wr_ctrl = reg_we && (reg_addr == `RTCSQ_OFS_CONTROL);

  // seconds: host write beats the tick in the same cycle
  always_comb begin
    next_seconds = seconds_count;
    if (wr_sec) begin
      next_seconds = reg_wdata & `RTCSQ_MASK_SECONDS;
    end else if (sec_wrap) begin
      next_seconds = {seconds_count[7], 7'h00};
    end else if (tick) begin
      next_seconds = {seconds_count[7], sec_inc[6:0]};
    end
  end

  // minutes
  always_comb begin
    next_minutes = minutes_count;
    if (wr_min) begin
      next_minutes = reg_wdata & `RTCSQ_MASK_MINUTES;
    end else if (min_wrap) begin
      next_minutes = 8'h00;
    end else if (sec_wrap) begin
      next_minutes = bcd_inc(minutes_count);
    end
  end

  // hours in either format; format bit kept across counting
  always_comb begin
    next_hours = hours_count;
    if (wr_hour) begin
      next_hours = reg_wdata & `RTCSQ_MASK_HOURS;
    end else if (min_wrap) begin
      if (fmt12) begin
        if (hr12 == 5'h12) begin
          next_hours = {2'b01, pm, 5'h01};
        end else if (hr12 == 5'h11) begin
          next_hours = {2'b01, ~pm, 5'h12};
        end else begin
          next_hours = {2'b01, pm, hr12_inc[4:0]};
        end
      end else if (day_wrap) begin
        next_hours = 8'h00;
      end else begin
        next_hours = {2'b00, hr24_inc[5:0]};
      end
    end
  end

  // weekday 1..7
  always_comb begin
    next_weekday = weekday_count;
    if (wr_wday) begin
      next_weekday = reg_wdata & `RTCSQ_MASK_WEEKDAY;
    end else if (day_wrap) begin
      next_weekday = (weekday_count[2:0] == 3'h7) ? 8'h01
                                                  : {5'h00, weekday_count[2:0] + 3'h1};
    end
  end

  // date
  always_comb begin
    next_date = date_count;
    if (wr_date) begin
      next_date = reg_wdata & `RTCSQ_MASK_DATE;
    end else if (date_wrap) begin
      next_date = 8'h01;
    end else if (day_wrap) begin
      next_date = bcd_inc(date_count);
    end
  end

  // month
  always_comb begin
    next_month = month_count;
    if (wr_mon) begin
      next_month = reg_wdata & `RTCSQ_MASK_MONTH;
    end else if (mon_wrap) begin
      next_month = 8'h01;
    end else if (date_wrap) begin
      next_month = bcd_inc(month_count);
    end
  end

  // year 00..99
  always_comb begin
    next_year = year_count;
    if (wr_year) begin
      next_year = reg_wdata & `RTCSQ_MASK_YEAR;
    end else if (mon_wrap) begin
      next_year = (year_count == 8'h99) ? 8'h00 : bcd_inc(year_count);
    end
  end

  // counter and control flip-flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seconds_count       <= `RTCSQ_RST_COUNT;
      minutes_count       <= `RTCSQ_RST_COUNT;
      hours_count         <= `RTCSQ_RST_COUNT;
      weekday_count       <= `RTCSQ_RST_WEEKDAY;
      date_count          <= `RTCSQ_RST_DATE;
      month_count         <= `RTCSQ_RST_MONTH;
      year_count          <= `RTCSQ_RST_COUNT;
      wave_output_control <= `RTCSQ_RST_CONTROL;
    end else begin
      seconds_count       <= next_seconds;
      minutes_count       <= next_minutes;
      hours_count         <= next_hours;
      weekday_count       <= next_weekday;
      date_count          <= next_date;
      month_count         <= next_month;
      year_count          <= next_year;
      if (wr_ctrl) begin
        wave_output_control <= reg_wdata & `RTCSQ_MASK_CONTROL;
      end
    end
  end

  // read mux; stored values already hold zeros in fixed bits
  // all eight offsets decode, the default only guards unknown addresses
  always_comb begin
    case (reg_addr)
      `RTCSQ_OFS_SECONDS: next_rdata = seconds_count;
      `RTCSQ_OFS_MINUTES: next_rdata = minutes_count;
      `RTCSQ_OFS_HOURS:   next_rdata = hours_count;
      `RTCSQ_OFS_WEEKDAY: next_rdata = weekday_count;
      `RTCSQ_OFS_DATE:    next_rdata = date_count;
      `RTCSQ_OFS_MONTH:   next_rdata = month_count;
      `RTCSQ_OFS_YEAR:    next_rdata = year_count;
      `RTCSQ_OFS_CONTROL: next_rdata = wave_output_control;
      default:            next_rdata = 8'h00;
    endcase
  end

  // read data held until the next read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : rtcsq_core

// ---- rtl/rtcsq_pkg.sv ----
// types shared by the clock core
// assumes rtcsq_cfg.svh holds all numeric constants
package rtcsq_pkg;

  // square-wave rate select encoding
  typedef enum logic [1:0] {
    RTCSQ_RATE_1HZ    = 2'b00,
    RTCSQ_RATE_4096HZ = 2'b01,
    RTCSQ_RATE_8192HZ = 2'b10,
    RTCSQ_RATE_32KHZ  = 2'b11
  } rtcsq_rate_e;

  typedef logic [7:0] rtcsq_byte_t;

endpackage : rtcsq_pkg

// ---- tb/rtcsq_chk.sv ----
// port checker for the clock core
// assumes bind onto rtcsq_core; control is shadowed from port writes
`timescale 1ns/1ps
`include "rtcsq_cfg.svh"
module rtcsq_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       osc_pin,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we,
  input wire logic       reg_re,
  input wire logic [7:0] reg_rdata,
  input wire logic       wave_output_pin,
  input wire logic       second_tick
);
  logic [7:0] ctl;
  logic       halt;
  logic [2:0] rd_addr;
  logic       rd_seen;
  wire [63:0] masks = {`RTCSQ_MASK_CONTROL, `RTCSQ_MASK_YEAR, `RTCSQ_MASK_MONTH, `RTCSQ_MASK_DATE,
                       `RTCSQ_MASK_WEEKDAY, `RTCSQ_MASK_HOURS, `RTCSQ_MASK_MINUTES, `RTCSQ_MASK_SECONDS};
  wire [7:0]  rd_mask = masks[rd_addr*8 +: 8];
  wire        one_hz  = ctl[4] && ctl[1:0] == 2'b00;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // shadow state; counters never touch these bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl     <= `RTCSQ_RST_CONTROL;
      halt    <= 1'b0;
      rd_addr <= 3'h0;
      rd_seen <= 1'b0;
    end else begin
      if (reg_we && reg_addr == `RTCSQ_OFS_CONTROL) ctl <= reg_wdata & `RTCSQ_MASK_CONTROL;
      if (reg_we && reg_addr == `RTCSQ_OFS_SECONDS) halt <= reg_wdata[7];
      if (reg_re) rd_addr <= reg_addr;
      if (reg_re) rd_seen <= 1'b1;
    end
  end
  a_idle_level: assert property (!ctl[4] && $stable(ctl) |=> wave_output_pin == $past(ctl[7]))
    else $error("idle level wrong");
  a_fast_wave: assert property (ctl[4] && ctl[1:0] == 2'b11 && $stable(ctl)
    |-> ##[0:6] $changed(wave_output_pin))
    else $error("fast wave stuck");
  a_tick_fall: assert property (second_tick && one_hz
    |-> ##[0:1] (!wave_output_pin && $past(wave_output_pin, 3)))
    else $error("tick not on wave fall");
  a_tick_pulse: assert property (second_tick |=> !second_tick)
    else $error("tick longer than one cycle");
  a_halt_quiet: assert property (halt && $past(halt, 4) |-> !second_tick)
    else $error("tick while halted");
  a_fixed_zero: assert property (rd_seen |-> (reg_rdata & ~rd_mask) == 8'h00)
    else $error("fixed zero bit set");
  a_ctl_back: assert property (reg_re && !reg_we && reg_addr == `RTCSQ_OFS_CONTROL |=> reg_rdata == ctl)
    else $error("control readback wrong");
  a_sec_range: assert property (reg_re && reg_addr == 3'h0
    |=> reg_rdata[6:4] <= 3'h5 && reg_rdata[3:0] <= 4'h9)
    else $error("seconds out of range");
  a_wday_range: assert property (reg_re && reg_addr == 3'h3 |=> reg_rdata inside {[8'h01:8'h07]})
    else $error("weekday out of range");
  a_hour_twelve: assert property (reg_re && reg_addr == 3'h2 && !reg_we |=>
    !reg_rdata[6] || reg_rdata[4:0] inside {[5'h01:5'h09], [5'h10:5'h12]})
    else $error("12h hour out of range");
endmodule : rtcsq_chk
bind rtcsq_core rtcsq_chk u_chk (.clk(clk), .nrst(nrst), .osc_pin(osc_pin), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .wave_output_pin(wave_output_pin), .second_tick(second_tick));

// ---- tb/rtcsq_host.sv ----
// host model: byte register master plus a scaled oscillator source
// assumes the core samples on rising clk; all driving on falling clk
`timescale 1ns/1ps
module rtcsq_host (
  input  wire logic       clk,
  output logic            osc_pin,
  output logic      [2:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_we,
  output logic            reg_re,
  input  wire logic [7:0] reg_rdata
);
  initial osc_pin = 1'b0;
  initial reg_addr = 3'h0;
  initial reg_wdata = 8'h00;
  initial reg_we = 1'b0;
  initial reg_re = 1'b0;
  // one clk per level: changes off the sampling edge, so every level is seen
  // and a second stays at 65536 clk, which keeps two carries inside the run
  always @(negedge clk) begin
    osc_pin <= ~osc_pin;
  end
  // released lines show inverted data so stale values cannot pass
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk);
    reg_we = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge clk);
    reg_re = 1'b0;
    reg_addr = ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : rtcsq_host

// ---- tb/tb.sv ----
// self-checking bench for the clock core
// assumes host model drives all inputs but clk and nrst; each second is 65536 clk
`timescale 1ns/1ps
`include "rtcsq_cfg.svh"
module tb;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  wire logic  osc_pin, reg_we, reg_re, wave_output_pin, second_tick;
  wire logic [2:0] reg_addr;
  wire logic [7:0] reg_wdata, reg_rdata;
  int         num_errors = 0;
  int         checks = 0;
  always #12.5 clk = ~clk;
  rtcsq_host u_host (.clk(clk), .osc_pin(osc_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  rtcsq_core u_dut (.clk(clk), .nrst(nrst), .osc_pin(osc_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .wave_output_pin(wave_output_pin),
    .second_tick(second_tick));
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk($sformatf("reg %0d", a), exp, d);
  endtask : rdchk
  task give_verdict;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // loads a moment one second before a carry, hours first, seconds last to start
  task load(input logic [7:0] h, w, d, m, y);
    int n;
    u_host.wr(3'h2, h);
    u_host.wr(3'h1, 8'h59);
    u_host.wr(3'h3, w);
    u_host.wr(3'h4, d);
    u_host.wr(3'h5, m);
    u_host.wr(3'h6, y);
    u_host.wr(3'h0, 8'h59);
    n = 0;
    while (second_tick !== 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    chk("tick seen", 8'h01, {7'h0, second_tick});
  endtask : load
  task automatic t_reset;
    logic [7:0] e [8] = '{`RTCSQ_RST_COUNT, `RTCSQ_RST_COUNT, `RTCSQ_RST_COUNT, `RTCSQ_RST_WEEKDAY,
                          `RTCSQ_RST_DATE, `RTCSQ_RST_MONTH, `RTCSQ_RST_COUNT, `RTCSQ_RST_CONTROL};
    for (int a = 0; a < 8; a++) rdchk(a[2:0], e[a]);
  endtask : t_reset
  // fixed-zero bits set in every write to a register that has them, field values kept legal
  task automatic t_masks;
    logic [7:0] w [8] = '{8'h59, 8'hD9, 8'hD2, 8'hFD, 8'hD5, 8'hE9, 8'h42, 8'hFF};
    logic [7:0] m [8] = '{`RTCSQ_MASK_SECONDS, `RTCSQ_MASK_MINUTES, `RTCSQ_MASK_HOURS, `RTCSQ_MASK_WEEKDAY,
                          `RTCSQ_MASK_DATE, `RTCSQ_MASK_MONTH, `RTCSQ_MASK_YEAR, `RTCSQ_MASK_CONTROL};
    for (int a = 0; a < 8; a++) u_host.wr(a[2:0], w[a]);
    for (int a = 0; a < 8; a++) rdchk(a[2:0], w[a] & m[a]);
  endtask : t_masks
  // rising edges in 512 clk: 2 clk per osc period
  task automatic t_rates;
    int e [4] = '{0, 32, 64, 256};
    int n;
    logic p;
    for (int r = 0; r < 4; r++) begin
      u_host.wr(3'h7, 8'h10 | r[7:0]);
      n = 0;
      p = wave_output_pin;
      repeat (512) begin
        @(negedge clk);
        if (wave_output_pin && !p) n++;
        p = wave_output_pin;
      end
      chk($sformatf("rate %0d near", r), 8'h01, {7'h0, n <= e[r] + 1 && n + 1 >= e[r]});
    end
    u_host.wr(3'h7, 8'h80);
    repeat (3) @(negedge clk);
    chk("idle high", 8'h01, {7'h0, wave_output_pin});
    u_host.wr(3'h7, 8'h00);
    repeat (3) @(negedge clk);
    chk("idle low", 8'h00, {7'h0, wave_output_pin});
  endtask : t_rates
  // 24h year end at 1 Hz wave: every counter carries at once
  task automatic t_year_end;
    logic [7:0] e [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    u_host.wr(3'h7, 8'h10);
    load(8'h23, 8'h07, 8'h31, 8'h12, 8'h99);
    for (int a = 0; a < 7; a++) rdchk(a[2:0], e[a]);
  endtask : t_year_end
  // halt keeps contents, then 11 PM to 12 AM in a leap February
  // a 4.096k wave taps the prescaler, so it must freeze while halted
  task automatic t_leap;
    logic [7:0] e [7] = '{8'h00, 8'h00, 8'h52, 8'h02, 8'h29, 8'h02, 8'h04};
    int n;
    logic p;
    u_host.wr(3'h7, 8'h11);
    u_host.wr(3'h0, 8'hD9);
    repeat (2) @(negedge clk);
    n = 0;
    p = wave_output_pin;
    repeat (100) begin
      @(negedge clk);
      if (wave_output_pin !== p) n++;
    end
    chk("halted wave moves", 8'h00, n[7:0]);
    rdchk(3'h0, 8'hD9);
    u_host.wr(3'h7, 8'h10);
    load(8'h71, 8'h01, 8'h28, 8'h02, 8'h04);
    for (int a = 0; a < 7; a++) rdchk(a[2:0], e[a]);
  endtask : t_leap
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_masks();
    t_rates();
    t_year_end();
    t_leap();
    give_verdict();
  end
  // two simulated seconds plus margin
  initial begin
    #(160000 * 25);
    num_errors++;
    give_verdict();
  end
endmodule : tb
